// [core/ucg_top.sv]
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module ucg_top (
  input wire logic MCLK_I,
  input wire logic RST_I,
  // AXI4-Lite write address channel.
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [ucg_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic [2:0] S_AXI_AWPROT_I,
  // AXI4-Lite write data channel.
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [ucg_pkg::DATA_W-1:0] S_AXI_WDATA_I,
  input wire logic [ucg_pkg::STRB_W-1:0] S_AXI_WSTRB_I,
  // AXI4-Lite write response channel.
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  // AXI4-Lite read address channel.
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [ucg_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic [2:0] S_AXI_ARPROT_I,
  // AXI4-Lite read data channel.
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [ucg_pkg::DATA_W-1:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  // Power mode requests from the mode controller.
  input wire logic SLEEP_I,
  input wire logic DEEP_SLEEP_I,
  // Unit access requests, one bit per gate position, and the fault answer.
  input wire logic [ucg_pkg::DATA_W-1:0] UNIT_ACCESS0_I,
  input wire logic [ucg_pkg::DATA_W-1:0] UNIT_ACCESS1_I,
  output logic UNIT_FAULT_O,
  // Effective enables and the gated unit clocks.
  output logic [ucg_pkg::DATA_W-1:0] UNIT_CLK_EN0_O,
  output logic [ucg_pkg::DATA_W-1:0] UNIT_CLK_EN1_O,
  output logic [ucg_pkg::DATA_W-1:0] UNIT_CLK0_O,
  output logic [ucg_pkg::DATA_W-1:0] UNIT_CLK1_O
);

  import ucg_pkg::*;

  // -----------------------------------------------------------------------
  // Functions
  // -----------------------------------------------------------------------

  // Decodes a byte address into a one-hot register select.
  // Addresses that are not word aligned or not mapped give all zeros.
  function automatic logic [NUM_REGS-1:0] decode_addr(
    input logic [ADDR_W-1:0] addr
  );
    logic [NUM_REGS-1:0] sel;
    sel = '0;
    sel[SEL_RUN0] = (addr == OFF_RUN_GATE0);
    sel[SEL_RUN1] = (addr == OFF_RUN_GATE1);
    sel[SEL_SLEEP0] = (addr == OFF_SLEEP_GATE0);
    sel[SEL_SLEEP1] = (addr == OFF_SLEEP_GATE1);
    sel[SEL_DEEP0] = (addr == OFF_DEEP_GATE0);
    sel[SEL_DEEP1] = (addr == OFF_DEEP_GATE1);
    sel[SEL_CFG] = (addr == OFF_RUN_CLOCK_CONFIG);
    return sel;
  endfunction : decode_addr

  // Merges write data into a register under byte strobes and a mask.
  // Bits outside the mask always come back as zero, so reserved bits
  // can never be set whatever software writes.
  function automatic logic [DATA_W-1:0] merge_write(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] wdata,
    input logic [STRB_W-1:0] strb,
    input logic [DATA_W-1:0] mask
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return res & mask;
  endfunction : merge_write

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [STRB_W-1:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rresp;

  logic [DATA_W-1:0] run_unit_gate_group0;
  logic [DATA_W-1:0] run_unit_gate_group1;
  logic [DATA_W-1:0] sleep_unit_gate_group0;
  logic [DATA_W-1:0] sleep_unit_gate_group1;
  logic [DATA_W-1:0] deep_sleep_unit_gate_group0;
  logic [DATA_W-1:0] deep_sleep_unit_gate_group1;
  logic [DATA_W-1:0] run_clock_config;

  logic [DATA_W-1:0] gate_en0;
  logic [DATA_W-1:0] gate_en1;
  logic [DATA_W-1:0] clk_en_latch0;
  logic [DATA_W-1:0] clk_en_latch1;

  // -----------------------------------------------------------------------
  // Write channel
  // -----------------------------------------------------------------------

  // Address and data are each taken once and held until the write is done,
  // so the master may present them in either order.
  wire aw_take = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  wire w_take = S_AXI_WVALID_I & S_AXI_WREADY_O;
  wire write_fire = aw_held & w_held & ~bvalid;
  wire [NUM_REGS-1:0] wr_sel = decode_addr(aw_addr);
  wire [NUM_REGS-1:0] wr_hit = write_fire ? wr_sel : '0;
  wire wr_mapped = |wr_sel;

  // Ready is withheld while a request is parked, giving one write at a time.
  assign S_AXI_AWREADY_O = ~aw_held;
  assign S_AXI_WREADY_O = ~w_held;

  // Capture of the write address.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR_I;
    end else if (write_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Capture of the write data and strobes.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA_I;
      w_strb <= S_AXI_WSTRB_I;
    end else if (write_fire) begin
      w_held <= 1'b0;
    end
  end

  // Write response; an unmapped address is refused with a slave error.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (write_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      bvalid <= 1'b0;
    end
  end

  assign S_AXI_BVALID_O = bvalid;
  assign S_AXI_BRESP_O = bresp;

  // -----------------------------------------------------------------------
  // Gate registers
  // -----------------------------------------------------------------------

  // Group 0 sets share one writable mask; only the converter, keeper and
  // watchdog positions hold state, everything else reads back zero.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      run_unit_gate_group0 <= RST_GROUP0;
      sleep_unit_gate_group0 <= RST_GROUP0;
      deep_sleep_unit_gate_group0 <= RST_GROUP0;
    end else begin
      if (wr_hit[SEL_RUN0]) begin
        run_unit_gate_group0 <= merge_write(run_unit_gate_group0, w_data,
                                            w_strb, MASK_GROUP0);
      end
      if (wr_hit[SEL_SLEEP0]) begin
        sleep_unit_gate_group0 <= merge_write(sleep_unit_gate_group0,
                                              w_data, w_strb, MASK_GROUP0);
      end
      if (wr_hit[SEL_DEEP0]) begin
        deep_sleep_unit_gate_group0 <= merge_write(
          deep_sleep_unit_gate_group0, w_data, w_strb, MASK_GROUP0
        );
      end
    end
  end

  // Group 1 sets: comparators, counters, two-wire, sync and async serial.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      run_unit_gate_group1 <= RST_GROUP1;
      sleep_unit_gate_group1 <= RST_GROUP1;
      deep_sleep_unit_gate_group1 <= RST_GROUP1;
    end else begin
      if (wr_hit[SEL_RUN1]) begin
        run_unit_gate_group1 <= merge_write(run_unit_gate_group1, w_data,
                                            w_strb, MASK_GROUP1);
      end
      if (wr_hit[SEL_SLEEP1]) begin
        sleep_unit_gate_group1 <= merge_write(sleep_unit_gate_group1,
                                              w_data, w_strb, MASK_GROUP1);
      end
      if (wr_hit[SEL_DEEP1]) begin
        deep_sleep_unit_gate_group1 <= merge_write(
          deep_sleep_unit_gate_group1, w_data, w_strb, MASK_GROUP1
        );
      end
    end
  end

  // Run-mode clock configuration holding the automatic gating select.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      run_clock_config <= RST_CFG;
    end else if (wr_hit[SEL_CFG]) begin
      run_clock_config <= merge_write(run_clock_config, w_data, w_strb,
                                      MASK_CFG);
    end
  end

  // -----------------------------------------------------------------------
  // Read channel
  // -----------------------------------------------------------------------

  wire ar_take = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
  wire [NUM_REGS-1:0] rd_sel = decode_addr(S_AXI_ARADDR_I);
  wire rd_mapped = |rd_sel;

  // The read mux is a plain AND-OR over the one-hot select.
  wire [DATA_W-1:0] rd_value =
    ({DATA_W{rd_sel[SEL_RUN0]}} & run_unit_gate_group0) |
    ({DATA_W{rd_sel[SEL_RUN1]}} & run_unit_gate_group1) |
    ({DATA_W{rd_sel[SEL_SLEEP0]}} & sleep_unit_gate_group0) |
    ({DATA_W{rd_sel[SEL_SLEEP1]}} & sleep_unit_gate_group1) |
    ({DATA_W{rd_sel[SEL_DEEP0]}} & deep_sleep_unit_gate_group0) |
    ({DATA_W{rd_sel[SEL_DEEP1]}} & deep_sleep_unit_gate_group1) |
    ({DATA_W{rd_sel[SEL_CFG]}} & run_clock_config);

  // Only one read is outstanding; a new address waits for the data taken.
  assign S_AXI_ARREADY_O = ~rvalid;

  // Read data register; unmapped reads return zero with a slave error.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata <= rd_value;
      rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      rvalid <= 1'b0;
    end
  end

  assign S_AXI_RVALID_O = rvalid;
  assign S_AXI_RDATA_O = rdata;
  assign S_AXI_RRESP_O = rresp;

  // -----------------------------------------------------------------------
  // Mode selection of the active gate set
  // -----------------------------------------------------------------------

  // Without automatic gating the run set stays in force in every mode,
  // so sleeping never drops a unit that software left enabled.
  wire auto_gating_select = run_clock_config[BIT_AUTO_GATING_SELECT];
  wire use_deep = auto_gating_select & DEEP_SLEEP_I;
  wire use_sleep = auto_gating_select & SLEEP_I & ~DEEP_SLEEP_I;

  wire [DATA_W-1:0] next_gate_en0 =
    use_deep ? deep_sleep_unit_gate_group0 :
    use_sleep ? sleep_unit_gate_group0 : run_unit_gate_group0;
  wire [DATA_W-1:0] next_gate_en1 =
    use_deep ? deep_sleep_unit_gate_group1 :
    use_sleep ? sleep_unit_gate_group1 : run_unit_gate_group1;

  // Effective enables are registered so the gate latches see clean levels.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      gate_en0 <= RST_GROUP0;
      gate_en1 <= RST_GROUP1;
    end else begin
      gate_en0 <= next_gate_en0 & MASK_GROUP0;
      gate_en1 <= next_gate_en1 & MASK_GROUP1;
    end
  end

  assign UNIT_CLK_EN0_O = gate_en0;
  assign UNIT_CLK_EN1_O = gate_en1;

  // -----------------------------------------------------------------------
  // Glitch-free clock gates
  // -----------------------------------------------------------------------

  // The enable is transparent only while the clock is low, so it can only
  // change the gate output between pulses; a pulse is never cut short.
  always_latch begin
    if (!MCLK_I) begin
      clk_en_latch0 = gate_en0;
      clk_en_latch1 = gate_en1;
    end
  end

  // A unit sees the system clock while its enable is one, and a steady low
  // level while it is zero. Unimplemented positions never toggle.
  assign UNIT_CLK0_O = {DATA_W{MCLK_I}} & clk_en_latch0;
  assign UNIT_CLK1_O = {DATA_W{MCLK_I}} & clk_en_latch1;

  // -----------------------------------------------------------------------
  // Bus fault on access to an unclocked unit
  // -----------------------------------------------------------------------

  // Checked against the enables in force this cycle, because that is the
  // clock the addressed unit actually has.
  wire [DATA_W-1:0] off_hit0 = UNIT_ACCESS0_I & ~gate_en0;
  wire [DATA_W-1:0] off_hit1 = UNIT_ACCESS1_I & ~gate_en1;
  assign UNIT_FAULT_O = (|off_hit0) | (|off_hit1);

endmodule : ucg_top

`default_nettype wire

// [include/ucg_pkg.sv]
package ucg_pkg;

  // ---------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int NUM_REGS = 7;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_RUN_GATE0 = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_RUN_GATE1 = 12'h104;
  localparam logic [ADDR_W-1:0] OFF_SLEEP_GATE0 = 12'h110;
  localparam logic [ADDR_W-1:0] OFF_SLEEP_GATE1 = 12'h114;
  localparam logic [ADDR_W-1:0] OFF_DEEP_GATE0 = 12'h120;
  localparam logic [ADDR_W-1:0] OFF_DEEP_GATE1 = 12'h124;
  localparam logic [ADDR_W-1:0] OFF_RUN_CLOCK_CONFIG = 12'h1F0;

  // Positions of the registers in the one-hot select vector.
  localparam int SEL_RUN0 = 0;
  localparam int SEL_RUN1 = 1;
  localparam int SEL_SLEEP0 = 2;
  localparam int SEL_SLEEP1 = 3;
  localparam int SEL_DEEP0 = 4;
  localparam int SEL_DEEP1 = 5;
  localparam int SEL_CFG = 6;

  // ---------------------------------------------------------------------
  // Field positions, group 0
  // ---------------------------------------------------------------------
  localparam int BIT_CONVERTER_GATE = 16;
  localparam int BIT_LOW_POWER_KEEPER_GATE = 6;
  localparam int BIT_WATCHDOG_GATE = 3;

  // ---------------------------------------------------------------------
  // Field positions, group 1
  // ---------------------------------------------------------------------
  localparam int BIT_COMPARATOR_ONE_GATE = 25;
  localparam int BIT_COMPARATOR_ZERO_GATE = 24;
  localparam int BIT_GP_COUNTER_THREE_GATE = 19;
  localparam int BIT_GP_COUNTER_TWO_GATE = 18;
  localparam int BIT_GP_COUNTER_ONE_GATE = 17;
  localparam int BIT_GP_COUNTER_ZERO_GATE = 16;
  localparam int BIT_TWO_WIRE_ONE_GATE = 14;
  localparam int BIT_TWO_WIRE_ZERO_GATE = 12;
  localparam int BIT_SYNC_SERIAL_ONE_GATE = 5;
  localparam int BIT_SYNC_SERIAL_ZERO_GATE = 4;
  localparam int BIT_ASYNC_SERIAL_ONE_GATE = 1;
  localparam int BIT_ASYNC_SERIAL_ZERO_GATE = 0;

  // Run-mode clock configuration: automatic gating select.
  localparam int BIT_AUTO_GATING_SELECT = 0;

  // ---------------------------------------------------------------------
  // Writable masks and values after reset
  // ---------------------------------------------------------------------
  localparam logic [DATA_W-1:0] MASK_GROUP0 = 32'h0001_0048;
  localparam logic [DATA_W-1:0] MASK_GROUP1 = 32'h030F_5033;
  localparam logic [DATA_W-1:0] MASK_CFG = 32'h0000_0001;
  localparam logic [DATA_W-1:0] RST_GROUP0 = 32'h0000_0040;
  localparam logic [DATA_W-1:0] RST_GROUP1 = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_CFG = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Bus response codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ucg_pkg

// [dv/ucg_checker.sv]
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------------
// Port-level checker for the unit clock gating block
// ---------------------------------------------------------------------
module ucg_checker (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [ucg_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_RVALID_O,
  input wire logic [ucg_pkg::DATA_W-1:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic [ucg_pkg::DATA_W-1:0] UNIT_ACCESS0_I,
  input wire logic [ucg_pkg::DATA_W-1:0] UNIT_ACCESS1_I,
  input wire logic UNIT_FAULT_O,
  input wire logic [ucg_pkg::DATA_W-1:0] UNIT_CLK_EN0_O,
  input wire logic [ucg_pkg::DATA_W-1:0] UNIT_CLK_EN1_O,
  input wire logic [ucg_pkg::DATA_W-1:0] UNIT_CLK0_O,
  input wire logic [ucg_pkg::DATA_W-1:0] UNIT_CLK1_O
);

  import ucg_pkg::*;

  // All checks share the system clock; only the high-phase one names the
  // falling edge, where the gated outputs are sampled mid-pulse.
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  // A read address is taken on any rising edge where valid meets ready.
  wire ar_fire = S_AXI_ARVALID_I & S_AXI_ARREADY_O;

  chk_fault_map: assert property (
    UNIT_FAULT_O == |((UNIT_ACCESS0_I & ~UNIT_CLK_EN0_O) |
      (UNIT_ACCESS1_I & ~UNIT_CLK_EN1_O))) else $error("fault mismatch");
  chk_res0_zero: assert property (
    (UNIT_CLK_EN0_O & ~MASK_GROUP0) == '0) else $error("group 0 spare");
  chk_res1_zero: assert property (
    (UNIT_CLK_EN1_O & ~MASK_GROUP1) == '0) else $error("group 1 spare");
  chk_deep0_read: assert property (
    ar_fire && S_AXI_ARADDR_I == OFF_DEEP_GATE0 |=> S_AXI_RVALID_O &&
      S_AXI_RRESP_O == RESP_OKAY && (S_AXI_RDATA_O & ~MASK_GROUP0) == '0)
    else $error("deep group 0 read wrong");
  chk_run1_read: assert property (
    ar_fire && S_AXI_ARADDR_I == OFF_RUN_GATE1 |=> S_AXI_RVALID_O &&
      S_AXI_RRESP_O == RESP_OKAY && (S_AXI_RDATA_O & ~MASK_GROUP1) == '0)
    else $error("run group 1 read wrong");
  chk_misalign_read: assert property (
    ar_fire && S_AXI_ARADDR_I[1:0] != 2'h0 |=> S_AXI_RVALID_O &&
      S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == '0)
    else $error("misaligned read not refused");
  chk_gate_low: assert property (
    UNIT_CLK0_O == '0 && UNIT_CLK1_O == '0) else $error("clock not low");
  // The latch holds the enable seen during the low phase before each rise.
  chk_gate_high: assert property (@(negedge MCLK_I)
    UNIT_CLK0_O == $past(UNIT_CLK_EN0_O) &&
      UNIT_CLK1_O == $past(UNIT_CLK_EN1_O)) else $error("gated clock wrong");
  chk_reset_val: assert property ($fell(RST_I) |->
    UNIT_CLK_EN0_O == RST_GROUP0 && UNIT_CLK_EN1_O == RST_GROUP1)
    else $error("enable after reset wrong");

endmodule : ucg_checker

bind ucg_top ucg_checker chk_u (.MCLK_I(MCLK_I), .RST_I(RST_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
  .UNIT_ACCESS0_I(UNIT_ACCESS0_I), .UNIT_ACCESS1_I(UNIT_ACCESS1_I),
  .UNIT_FAULT_O(UNIT_FAULT_O), .UNIT_CLK_EN0_O(UNIT_CLK_EN0_O),
  .UNIT_CLK_EN1_O(UNIT_CLK_EN1_O), .UNIT_CLK0_O(UNIT_CLK0_O),
  .UNIT_CLK1_O(UNIT_CLK1_O));

`default_nettype wire

// [dv/unit_clock_gating_regs_test.sv]
`timescale 1ns/100ps
`default_nettype none

module unit_clock_gating_regs_test;
  import ucg_pkg::*;

  // ---------------------------------------------------------------------
  // Signals and the expected register image
  // ---------------------------------------------------------------------
  logic mclk, rst, awvalid, wvalid, bready, arvalid, rready, sleep_q, deep_q;
  logic awready, wready, bvalid, arready, rvalid, fault;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, acc0, acc1, en0, en1, gclk0, gclk1;
  logic [STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] regs [7];
  int error_cnt, checked, cycles;
  // Index order is run, sleep, deep (group 0 then 1), then the config.
  logic [ADDR_W-1:0] offs [7] = '{12'h100, 12'h104, 12'h110, 12'h114,
    12'h120, 12'h124, 12'h1F0};
  logic [DATA_W-1:0] masks [7] = '{32'h0001_0048, 32'h030F_5033,
    32'h0001_0048, 32'h030F_5033, 32'h0001_0048, 32'h030F_5033, 32'h1};
  logic [DATA_W-1:0] resets [7] = '{32'h0000_0040, 32'h0, 32'h0000_0040,
    32'h0, 32'h0000_0040, 32'h0, 32'h0};

  ucg_top dut_u (.MCLK_I(mclk), .RST_I(rst),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWPROT_I(3'h0),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_BRESP_O(bresp),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARPROT_I(3'h0),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .SLEEP_I(sleep_q), .DEEP_SLEEP_I(deep_q),
    .UNIT_ACCESS0_I(acc0), .UNIT_ACCESS1_I(acc1), .UNIT_FAULT_O(fault),
    .UNIT_CLK_EN0_O(en0), .UNIT_CLK_EN1_O(en1),
    .UNIT_CLK0_O(gclk0), .UNIT_CLK1_O(gclk1));

  // ---------------------------------------------------------------------
  // Expectation helpers
  // ---------------------------------------------------------------------
  // Byte lanes merge into the old value; spare bits never take a write.
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
    input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s, input int i);
    logic [DATA_W-1:0] m;
    for (int b = 0; b < STRB_W; b++) m[8*b+:8] = {8{s[b]}};
    return ((o & ~m) | (d & m)) & masks[i];
  endfunction : merge

  // Deep sleep wins over sleep, and both count only with auto gating on.
  function automatic logic [DATA_W-1:0] exp_en(input int g);
    int s;
    s = (regs[6][0] != 1'b1) ? 0 : deep_q ? 4 : sleep_q ? 2 : 0;
    return regs[s+g];
  endfunction : exp_en

  task automatic chk(input string nm, input logic [DATA_W-1:0] e,
    input logic [DATA_W-1:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // ---------------------------------------------------------------------
  // Bus master tasks
  // ---------------------------------------------------------------------
  // Ready is sampled at the falling edge, where it is settled for the rise.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic [STRB_W-1:0] s, output logic [1:0] r);
    logic ta, tw, done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done) begin
      @(negedge mclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      done = bvalid;
      r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
    output logic [1:0] r);
    logic ta, done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(negedge mclk);
      ta = arvalid & arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
    end
  endtask : rd

  task automatic results();
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // ---------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ---------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // A hung handshake would stall the run, so the cycle count is capped.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    logic [DATA_W-1:0] d, x, e;
    logic [STRB_W-1:0] s;
    logic [1:0] r;
    int i;
    rst <= 1'b1;
    {awvalid, wvalid, arvalid, bready, rready, sleep_q, deep_q} <= 7'h0;
    {awaddr, araddr, wstrb} <= 28'h0;
    {wdata, acc0, acc1} <= 96'h0;
    regs = resets;
    d = $urandom(2);
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    {bready, rready} <= 2'h3;
    @(posedge mclk);
    for (i = 0; i < 7; i++) begin
      rd(offs[i], d, r);
      chk("reset value", resets[i], d);
    end
    // All ones, then all zeros, then random data with random byte lanes.
    for (int k = 0; k < 60; k++) begin
      i = k < 14 ? k % 7 : $urandom_range(6, 0);
      d = k < 7 ? 32'hFFFF_FFFF : k < 14 ? 32'h0 : $urandom;
      x = $urandom;
      s = k < 14 ? 4'hF : x[3:0];
      wr(offs[i], d, s, r);
      chk("write resp", 32'h0, {30'h0, r});
      regs[i] = merge(regs[i], d, s, i);
      rd(offs[i], d, r);
      if (i % 2 == 1 && i < 6) begin
        chk("hi", regs[i] >> 16, d >> 16);
        chk("lo", regs[i] & 32'hFFFF, d & 32'hFFFF);
      end else begin
        chk("g0 or cfg", regs[i], d);
      end
    end
    wr(12'h108, 32'hFFFF_FFFF, 4'hF, r);
    chk("unmapped wr", 32'h2, {30'h0, r});
    rd(12'h108, d, r);
    chk("unmapped rd", 32'h2, {30'h0, r});
    wr(12'h122, 32'hFFFF_FFFF, 4'hF, r);
    chk("misaligned wr", 32'h2, {30'h0, r});
    rd(12'h121, d, r);
    chk("misaligned rd", 32'h2, {30'h0, r});
    rd(12'h120, d, r);
    chk("deep0 kept", regs[4], d);
    // Software style update: read, set the watchdog gate, write it back
    // with the reserved bits exactly as they were read.
    rd(12'h120, d, r);
    d = d | 32'h8;
    wr(12'h120, d, 4'hF, r);
    regs[4] = merge(regs[4], d, 4'hF, 4);
    rd(12'h120, d, r);
    chk("deep0 rmw", regs[4], d);
    chk("watchdog gate", 32'h8, d & 32'h8);
    // Random register, mode and unit access mixes; units sit one-hot.
    for (int k = 0; k < 80; k++) begin
      i = $urandom_range(6, 0);
      d = $urandom;
      x = $urandom;
      wr(offs[i], d, 4'hF, r);
      regs[i] = merge(regs[i], d, 4'hF, i);
      sleep_q <= x[0];
      deep_q <= x[1];
      acc0 <= x[2] ? 32'h1 << x[12:8] : 32'h0;
      acc1 <= x[3] ? 32'h1 << x[20:16] : 32'h0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("enable g0", exp_en(0), en0);
      chk("enable g1", exp_en(1), en1);
      e = {31'h0, |((acc0 & ~exp_en(0)) | (acc1 & ~exp_en(1)))};
      chk("fault", e, {31'h0, fault});
      @(posedge mclk);
    end
    results();
  end

endmodule : unit_clock_gating_regs_test

`default_nettype wire
